// file: core/eisv_consts.svh
`ifndef EISV_CONSTS_SVH
`define EISV_CONSTS_SVH

// register byte offsets on the bus
`define EISV_OFS_SENSE 8'h00
`define EISV_OFS_STATUS 8'h04
`define EISV_OFS_VECTOR 8'h08

// sense control reset value and field positions
`define EISV_SENSE_RST 8'h00
`define EISV_C_SEL_LSB 6
`define EISV_C_INV_BIT 5
`define EISV_B_SEL_LSB 3
`define EISV_A_SEL_LSB 1
`define EISV_A_INV_BIT 0

// vector map
`define EISV_NVEC 14
`define EISV_VEC_TOP 16'hFFFA
`define EISV_VEC_GRP_A 4'h2
`define EISV_VEC_GRP_B 4'h3
`define EISV_VEC_GRP_C 4'h4

// wake masks per vector, bit n is vector n
`define EISV_WAKE_HALT 14'h111C
`define EISV_WAKE_AHALT 14'h111E

`endif

// file: core/eisv_pin_sense.sv
module eisv_pin_sense #(
   parameter int NPIN = 3,
   parameter int NINV = 0
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // pins of the group
   input wire logic [NPIN-1:0] pin_level,
   input wire logic [NPIN-1:0] pin_irq_en,
   input wire logic [NPIN-1:0] pin_grounded,
   // configuration
   input wire eisv_pkg::eisv_sense_t sense_sel,
   input wire logic invert,
   input wire logic clear,
   // group request
   output logic group_req_q
);

   logic [NPIN-1:0] prev_q;
   logic [NPIN-1:0] pol;
   logic [NPIN-1:0] fall;
   logic [NPIN-1:0] rise;
   logic [NPIN-1:0] edge_hit;
   logic [NPIN-1:0] level_hit;
   logic latch_q;
   logic latch_d;
   logic masked;

   // edges come from the raw pins so a polarity change makes no false edge
   generate
      for (genvar i = 0; i < NPIN; i++) begin : g_pin
         assign pol[i] = invert & (i >= NPIN - NINV);
         assign fall[i] = pol[i] ? (~prev_q[i] & pin_level[i]) : (prev_q[i] & ~pin_level[i]);
         assign rise[i] = pol[i] ? (prev_q[i] & ~pin_level[i]) : (~prev_q[i] & pin_level[i]);
         assign edge_hit[i] = pin_irq_en[i] & ((sense_sel == eisv_pkg::EISV_RISE) ? rise[i] :
                              (sense_sel == eisv_pkg::EISV_BOTH) ? (rise[i] | fall[i]) : fall[i]);
         assign level_hit[i] = pin_irq_en[i] & (sense_sel == eisv_pkg::EISV_FALL_LOW) &
                               ~(pin_level[i] ^ pol[i]);
      end
   endgenerate

   assign masked = |(pin_irq_en & pin_grounded);
   // a new edge in the clearing cycle survives
   assign latch_d = (latch_q & ~clear) | (|edge_hit);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         prev_q <= {NPIN{1'b1}};
         latch_q <= 1'b0;
         group_req_q <= 1'b0;
      end else begin
         prev_q <= pin_level;
         latch_q <= latch_d;
         group_req_q <= ~masked & (latch_d | (|level_hit));
      end
   end

endmodule

// file: core/eisv_pkg.sv
package eisv_pkg;

   typedef enum logic [1:0] {
      EISV_LVL2 = 2'b00,
      EISV_LVL1 = 2'b01,
      EISV_LVL0 = 2'b10,
      EISV_LVL3 = 2'b11
   } eisv_prio_t;

   typedef enum logic [1:0] {
      EISV_FALL_LOW = 2'b00,
      EISV_RISE = 2'b01,
      EISV_FALL = 2'b10,
      EISV_BOTH = 2'b11
   } eisv_sense_t;

endpackage

// file: core/eisv_top.sv
// Summary of operation
// - priority instructions reload current software priority
// - vector 0 highest, FFFAh, no stop wake
// - vector 1 shared time base, safe oscillator
// - vector 1 wakes timed sleep only
// - vectors 5 to 7 never wake
// - vectors 9 to 11 never wake
// - vector 12 shared, FFE2h, wakes
// - vector 13 lowest, FFE0h, no wake
// - changed sense write clears latched edge requests
// - grounded enabled pin masks its group
// - three independent sensitivity settings supported
// - sense writes only at level 3
// - sense register resets 00h, fixed layout
// - group C invertible pins encodings, inversion
// - other group C pins never invert
// - bit 5 inverts group C pins
// - group B four encodings, no inversion
// - group A upper pins invertible only
// - bit 0 inverts group A pins
// - rising plus high only groups A, C
// - edge request latched, cleared on entry
// - group pins ORed into one request
`include "eisv_consts.svh"

module eisv_top #(
   parameter int A_PINS = 6,
   parameter int B_PINS = 4,
   parameter int C_PINS = 6,
   parameter int A_INV = 3,
   parameter int C_INV = 3
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // external pins, per pin enable and ground detect
   input wire logic [A_PINS-1:0] ext_line_group_a,
   input wire logic [A_PINS-1:0] group_a_irq_en,
   input wire logic [A_PINS-1:0] group_a_grounded,
   input wire logic [B_PINS-1:0] ext_line_group_b,
   input wire logic [B_PINS-1:0] group_b_irq_en,
   input wire logic [B_PINS-1:0] group_b_grounded,
   input wire logic [C_PINS-1:0] ext_line_group_c,
   input wire logic [C_PINS-1:0] group_c_irq_en,
   input wire logic [C_PINS-1:0] group_c_grounded,
   // peripheral sources
   input wire logic motor_emergency_stop_req,
   input wire logic clock_time_base_req,
   input wire logic safe_osc_switch_req,
   input wire logic [2:0] motor_coprocessor_req,
   input wire logic spi_req,
   input wire logic timer_a_req,
   input wire logic timer_b_req,
   input wire logic serial_req,
   input wire logic aux_voltage_detect_req,
   input wire logic adc_eoc_req,
   input wire logic autoreload_pwm_timer_req,
   // cpu events
   input wire logic irq_enter,
   input wire logic [3:0] irq_enter_vec,
   input wire logic [1:0] irq_enter_prio,
   input wire logic irq_return_instr,
   input wire logic pop_flags_instr,
   input wire logic [1:0] popped_prio,
   input wire logic irq_enable_instr,
   input wire logic irq_disable_instr,
   input wire logic wait_for_irq_instr,
   input wire logic stop_instr,
   // to the cpu
   output logic irq_pending,
   output logic [3:0] irq_vec_num,
   output logic [15:0] irq_vec_addr,
   output logic wake_from_halt,
   output logic wake_from_active_halt,
   output logic [1:0] cpu_priority
);

   logic [7:0] sense_q;
   logic [31:0] rdata_q;
   logic hreadyout_q;
   logic wr_pend_q;
   logic [7:0] wr_ofs_q;
   eisv_pkg::eisv_prio_t cpu_prio_q;
   logic [2:0] grp_req_q;

   wire [7:0] rd_ofs = haddr[7:0];
   wire rd_sel = hsel & htrans[1] & ~hwrite & hready;
   wire wr_sel = hsel & htrans[1] & hwrite & hready & (hsize == 3'b010);
   wire wr_commit = wr_pend_q & (wr_ofs_q == `EISV_OFS_SENSE);
   wire prio_ok = cpu_prio_q == eisv_pkg::EISV_LVL3;
   wire sense_we = wr_commit & prio_ok;
   wire [7:0] sense_new = hwdata[7:0];
   wire cfg_change = sense_we & (sense_new != sense_q);

   wire [31:0] rd_mux = (rd_ofs == `EISV_OFS_SENSE) ? {24'h000000, sense_q} :
                        (rd_ofs == `EISV_OFS_STATUS) ? {26'h0000000, cpu_prio_q, 1'b0, grp_req_q} :
                        (rd_ofs == `EISV_OFS_VECTOR) ? {irq_pending, 11'h000, irq_vec_num, irq_vec_addr} :
                        32'h00000000;

   // field split of the sense register
   wire [1:0] c_sel = sense_q[`EISV_C_SEL_LSB+1:`EISV_C_SEL_LSB];
   wire c_inv = sense_q[`EISV_C_INV_BIT];
   wire [1:0] b_sel = sense_q[`EISV_B_SEL_LSB+1:`EISV_B_SEL_LSB];
   wire [1:0] a_sel = sense_q[`EISV_A_SEL_LSB+1:`EISV_A_SEL_LSB];
   wire a_inv = sense_q[`EISV_A_INV_BIT];

   // entering a group's routine drops its edge latch
   wire ack_a = irq_enter & (irq_enter_vec == `EISV_VEC_GRP_A);
   wire ack_b = irq_enter & (irq_enter_vec == `EISV_VEC_GRP_B);
   wire ack_c = irq_enter & (irq_enter_vec == `EISV_VEC_GRP_C);

   // priority instruction order: entry, return, pop, disable, enable/wait/stop
   wire [1:0] prio_d = irq_enter ? irq_enter_prio :
                       (irq_return_instr | pop_flags_instr) ? popped_prio :
                       irq_disable_instr ? eisv_pkg::EISV_LVL3 :
                       (irq_enable_instr | wait_for_irq_instr | stop_instr) ? eisv_pkg::EISV_LVL0 :
                       cpu_prio_q;

   wire [13:0] all_req = {autoreload_pwm_timer_req,
                          aux_voltage_detect_req | adc_eoc_req,
                          serial_req,
                          timer_b_req,
                          timer_a_req,
                          spi_req,
                          motor_coprocessor_req[2],
                          motor_coprocessor_req[1],
                          motor_coprocessor_req[0],
                          grp_req_q[2],
                          grp_req_q[1],
                          grp_req_q[0],
                          clock_time_base_req | safe_osc_switch_req,
                          motor_emergency_stop_req};

   assign hrdata = rdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = 1'b0 & hreadyout_q;
   assign cpu_priority = cpu_prio_q;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rdata_q <= 32'h00000000;
         hreadyout_q <= 1'b1;
         wr_pend_q <= 1'b0;
         wr_ofs_q <= 8'h00;
      end else begin
         rdata_q <= rd_sel ? rd_mux : 32'h00000000;
         hreadyout_q <= 1'b1;
         wr_pend_q <= wr_sel;
         wr_ofs_q <= wr_sel ? haddr[7:0] : wr_ofs_q;
      end
   end

   // writes below level 3 are dropped silently, software sees no error
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sense_q <= `EISV_SENSE_RST;
         cpu_prio_q <= eisv_pkg::EISV_LVL3;
      end else begin
         sense_q <= sense_we ? sense_new : sense_q;
         cpu_prio_q <= eisv_pkg::eisv_prio_t'(prio_d);
      end
   end

   // groups A and C take an inverter, B does not
   eisv_pin_sense #(
      .NPIN(A_PINS),
      .NINV(A_INV)
   ) u_grp_a (
      .clk_sys(clk_sys),
      .reset(reset),
      .pin_level(ext_line_group_a),
      .pin_irq_en(group_a_irq_en),
      .pin_grounded(group_a_grounded),
      .sense_sel(eisv_pkg::eisv_sense_t'(a_sel)),
      .invert(a_inv),
      .clear(ack_a | cfg_change),
      .group_req_q(grp_req_q[0])
   );

   eisv_pin_sense #(
      .NPIN(B_PINS),
      .NINV(0)
   ) u_grp_b (
      .clk_sys(clk_sys),
      .reset(reset),
      .pin_level(ext_line_group_b),
      .pin_irq_en(group_b_irq_en),
      .pin_grounded(group_b_grounded),
      .sense_sel(eisv_pkg::eisv_sense_t'(b_sel)),
      .invert(1'b0),
      .clear(ack_b | cfg_change),
      .group_req_q(grp_req_q[1])
   );

   eisv_pin_sense #(
      .NPIN(C_PINS),
      .NINV(C_INV)
   ) u_grp_c (
      .clk_sys(clk_sys),
      .reset(reset),
      .pin_level(ext_line_group_c),
      .pin_irq_en(group_c_irq_en),
      .pin_grounded(group_c_grounded),
      .sense_sel(eisv_pkg::eisv_sense_t'(c_sel)),
      .invert(c_inv),
      .clear(ack_c | cfg_change),
      .group_req_q(grp_req_q[2])
   );

   eisv_vec_arb #(
      .NV(`EISV_NVEC)
   ) u_arb (
      .clk_sys(clk_sys),
      .reset(reset),
      .src_req(all_req),
      .vec_valid_q(irq_pending),
      .vec_num_q(irq_vec_num),
      .vec_addr_q(irq_vec_addr),
      .wake_halt_q(wake_from_halt),
      .wake_active_halt_q(wake_from_active_halt)
   );

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   property p_prio_disable;
      irq_disable_instr && !irq_enter && !irq_return_instr && !pop_flags_instr
         |=> cpu_prio_q == eisv_pkg::EISV_LVL3;
   endproperty
   a_prio_disable: assert property (p_prio_disable) else $error("disable did not set level 3");

   // halt wake may only come from another halt-wake source present in the same cycle
   property p_vec0_top;
      motor_emergency_stop_req |=> irq_vec_num == 4'h0 && irq_vec_addr == 16'hFFFA &&
         (!wake_from_halt || $past((all_req & `EISV_WAKE_HALT) != 14'h0000));
   endproperty
   a_vec0_top: assert property (p_vec0_top) else $error("vector 0 not on top");

   property p_vec1;
      all_req[1] && !all_req[0] |=> irq_vec_num == 4'h1 && irq_vec_addr == 16'hFFF8;
   endproperty
   a_vec1: assert property (p_vec1) else $error("vector 1 wrong");

   property p_vec1_wake;
      (all_req & `EISV_WAKE_HALT) == 14'h0000 && clock_time_base_req
         |=> wake_from_active_halt && !wake_from_halt;
   endproperty
   a_vec1_wake: assert property (p_vec1_wake) else $error("time base wake wrong");

   property p_motor_nowake;
      (all_req & 14'h3F1F) == 14'h0000 && motor_coprocessor_req != 3'b000
         |=> !wake_from_halt && !wake_from_active_halt && irq_vec_num >= 4'h5 && irq_vec_num <= 4'h7;
   endproperty
   a_motor_nowake: assert property (p_motor_nowake) else $error("motor event woke device");

   property p_timer_nowake;
      (all_req & 14'h31FF) == 14'h0000 && all_req[11:9] != 3'b000 |=> !wake_from_halt;
   endproperty
   a_timer_nowake: assert property (p_timer_nowake) else $error("timer or serial woke device");

   property p_vec12;
      all_req == 14'h1000 |=> irq_vec_addr == 16'hFFE2 && wake_from_halt && wake_from_active_halt;
   endproperty
   a_vec12: assert property (p_vec12) else $error("vector 12 wrong");

   property p_vec13;
      all_req == 14'h2000 |=> irq_vec_num == 4'hD && irq_vec_addr == 16'hFFE0 && !wake_from_active_halt;
   endproperty
   a_vec13: assert property (p_vec13) else $error("vector 13 wrong");

   property p_ground_mask;
      (group_a_irq_en & group_a_grounded) != 6'h00 ##1 (group_a_irq_en & group_a_grounded) != 6'h00
         |-> !grp_req_q[0];
   endproperty
   a_ground_mask: assert property (p_ground_mask) else $error("grounded group not masked");

   property p_sense_locked;
      wr_commit && !prio_ok |=> $stable(sense_q);
   endproperty
   a_sense_locked: assert property (p_sense_locked) else $error("sense written below level 3");

   property p_sense_reset;
      disable iff (1'b0) reset |=> sense_q == 8'h00;
   endproperty
   a_sense_reset: assert property (p_sense_reset) else $error("sense reset value wrong");

   c_vec0: cover property (motor_emergency_stop_req ##1 irq_vec_num == 4'h0);
   c_cfg_write: cover property (cfg_change ##1 sense_q != 8'h00);
   c_wake_ext: cover property (grp_req_q != 3'b000 ##1 wake_from_halt);

endmodule

// file: core/eisv_vec_arb.sv
`include "eisv_consts.svh"

module eisv_vec_arb #(
   parameter int NV = `EISV_NVEC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // requests, bit n is vector n
   input wire logic [NV-1:0] src_req,
   // winner and wake
   output logic vec_valid_q,
   output logic [3:0] vec_num_q,
   output logic [15:0] vec_addr_q,
   output logic wake_halt_q,
   output logic wake_active_halt_q
);

   logic [3:0] win_num;
   logic [15:0] win_addr;

   // lowest vector number wins
   always_comb begin
      win_num = 4'h0;
      for (int k = NV - 1; k >= 0; k--) begin
         if (src_req[k]) begin
            win_num = 4'(k);
         end
      end
   end

   assign win_addr = `EISV_VEC_TOP - {11'h000, win_num, 1'b0};

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         vec_valid_q <= 1'b0;
         vec_num_q <= 4'h0;
         vec_addr_q <= 16'h0000;
         wake_halt_q <= 1'b0;
         wake_active_halt_q <= 1'b0;
      end else begin
         vec_valid_q <= |src_req;
         vec_num_q <= win_num;
         vec_addr_q <= win_addr;
         wake_halt_q <= |(src_req & `EISV_WAKE_HALT);
         wake_active_halt_q <= |(src_req & `EISV_WAKE_AHALT);
      end
   end

endmodule

// file: verification/eisv_cpu_model.sv
module eisv_cpu_model #(
   parameter int LAT = 2
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // bench control
   input wire logic ack_en,
   // from the controller
   input wire logic irq_pending,
   input wire logic [3:0] irq_vec_num,
   // routine entry
   output logic irq_enter,
   output logic [3:0] irq_enter_vec,
   output logic [1:0] irq_enter_prio
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   logic done;
   // one entry per enable, so a persisting level stays visible afterwards
   always @(posedge clk_sys) begin
      irq_enter <= 1'b0;
      if (reset || !ack_en) begin
         cnt <= 0;
         done <= 1'b0;
         irq_enter_vec <= 4'h0;
      end else if (!done && irq_pending === 1'b1) begin
         cnt <= cnt + 1;
         if (cnt == LAT) begin
            irq_enter <= 1'b1;
            irq_enter_vec <= irq_vec_num;
            done <= 1'b1;
         end
      end
   end
   assign irq_enter_prio = 2'b01;
endmodule

// file: verification/test_ext_irq_sensing_and_vector_map.sv
module test_ext_irq_sensing_and_vector_map;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [12:0] s; logic [3:0] n; logic [15:0] a; logic wh; logic wah;} eisv_row_t;
   eisv_row_t rows [14] = '{
      '{13'h0001, 4'h0, 16'hFFFA, 1'b0, 1'b0}, '{13'h0002, 4'h1, 16'hFFF8, 1'b0, 1'b1},
      '{13'h0004, 4'h1, 16'hFFF8, 1'b0, 1'b1}, '{13'h0008, 4'h5, 16'hFFF0, 1'b0, 1'b0},
      '{13'h0020, 4'h7, 16'hFFEC, 1'b0, 1'b0}, '{13'h0040, 4'h8, 16'hFFEA, 1'b1, 1'b1},
      '{13'h0080, 4'h9, 16'hFFE8, 1'b0, 1'b0}, '{13'h0100, 4'hA, 16'hFFE6, 1'b0, 1'b0},
      '{13'h0200, 4'hB, 16'hFFE4, 1'b0, 1'b0}, '{13'h0400, 4'hC, 16'hFFE2, 1'b1, 1'b1},
      '{13'h0800, 4'hC, 16'hFFE2, 1'b1, 1'b1}, '{13'h1000, 4'hD, 16'hFFE0, 1'b0, 1'b0},
      '{13'h1400, 4'hC, 16'hFFE2, 1'b1, 1'b1}, '{13'h1FFF, 4'h0, 16'hFFFA, 1'b1, 1'b1}};
   logic [5:0] pe [5] = '{6'h08, 6'h04, 6'h10, 6'h02, 6'h20};
   logic [1:0] pp [5] = '{2'b10, 2'b11, 2'b10, 2'b01, 2'b10};
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic hreadyout, hresp, ack_en = 1'b0, irq_enter, pend, wh, wah, v;
   logic [15:0] ln = 16'hFFFF, en = 16'h0;
   logic [5:0] gnd = 6'h0, ev = 6'h0;
   logic [12:0] src = 13'h0;
   logic [3:0] ent_vec, vnum;
   logic [1:0] ent_prio, prio, s;
   logic [15:0] vaddr;
   int err_total = 0, n_checks = 0, cyc = 0, g, k, c, b, p;

   always #10 clk_sys = ~clk_sys;

   eisv_top dut_u (.clk_sys(clk_sys), .reset(reset), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ext_line_group_a(ln[5:0]), .group_a_irq_en(en[5:0]),
      .group_a_grounded(gnd), .ext_line_group_b(ln[9:6]), .group_b_irq_en(en[9:6]),
      .group_b_grounded(4'h0), .ext_line_group_c(ln[15:10]), .group_c_irq_en(en[15:10]),
      .group_c_grounded(6'h0), .motor_emergency_stop_req(src[0]), .clock_time_base_req(src[1]),
      .safe_osc_switch_req(src[2]), .motor_coprocessor_req(src[5:3]), .spi_req(src[6]),
      .timer_a_req(src[7]), .timer_b_req(src[8]), .serial_req(src[9]), .aux_voltage_detect_req(src[10]),
      .adc_eoc_req(src[11]), .autoreload_pwm_timer_req(src[12]), .irq_enter(irq_enter),
      .irq_enter_vec(ent_vec), .irq_enter_prio(ent_prio), .irq_return_instr(ev[0]),
      .pop_flags_instr(ev[1]), .popped_prio(2'b01), .irq_enable_instr(ev[3]), .irq_disable_instr(ev[2]),
      .wait_for_irq_instr(ev[4]), .stop_instr(ev[5]), .irq_pending(pend), .irq_vec_num(vnum),
      .irq_vec_addr(vaddr), .wake_from_halt(wh), .wake_from_active_halt(wah), .cpu_priority(prio));

   eisv_cpu_model #(.LAT(2)) cpu_u (.clk_sys(clk_sys), .reset(reset), .ack_en(ack_en), .irq_pending(pend),
      .irq_vec_num(vnum), .irq_enter(irq_enter), .irq_enter_vec(ent_vec), .irq_enter_prio(ent_prio));

   task stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task chkv(input logic [31:0] gt, input logic [31:0] ex, input string m);
      n_checks++;
      if (gt !== ex) begin
         err_total++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, gt, ex);
      end
   endtask

   task chk1(input logic gt, input logic ex, input string m);
      chkv({31'h0, gt}, {31'h0, ex}, m);
   endtask

   // callers sit just after a rising edge; address phase held until hready
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'b010;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'b00;
      hwdata <= d;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      rd = hrdata;
      if (n >= 50) begin
         err_total++;
         stop_test();
      end
   endtask

   task rdst(input int bitn, input logic ex, input string m);
      // room for the cpu model to enter and the cleared latch to reach status
      repeat (5) @(posedge clk_sys);
      ahb(1'b0, 32'h4, 32'h0);
      chk1(rd[bitn], ex, m);
   endtask

   function automatic logic expv(input logic [1:0] sl, input logic iv, input logic pr, input logic nw);
      logic f, r;
      f = pr & ~nw;
      r = ~pr & nw;
      case (sl)
         2'b00: expv = iv ? (r | nw) : (f | ~nw);
         2'b01: expv = iv ? f : r;
         2'b10: expv = iv ? r : f;
         default: expv = f | r;
      endcase
   endfunction

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 6000) begin
         err_total++;
         stop_test();
      end
   end

   initial begin
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      #1;
      chkv({prio, hreadyout, hresp}, 4'hE, "reset outputs");
      @(posedge clk_sys);
      ahb(1'b0, 32'h0, 32'h0);
      chkv(rd, 32'h0, "sense reset value");
      foreach (rows[i]) begin
         src <= rows[i].s;
         repeat (2) @(posedge clk_sys);
         #1;
         chkv({pend, vnum, vaddr, wh, wah}, {1'b1, rows[i].n, rows[i].a, rows[i].wh, rows[i].wah}, "map");
         @(posedge clk_sys);
         src <= 13'h0;
         repeat (3) @(posedge clk_sys);
      end
      for (g = 0; g < 3; g++) begin
         for (k = 0; k < 2; k++) begin
            p = (k == 0) ? 0 : (g == 1 ? 3 : 5);
            b = (g == 0 ? 0 : g == 1 ? 6 : 10) + p;
            en <= 16'h0001 << b;
            for (c = 0; c < 8; c++) begin
               s = c[2:1];
               v = c[0] & (g != 1) & (p >= 3);
               ahb(1'b1, 32'h0, {24'h0, s, c[0], s, s, c[0]});
               rdst(g, expv(s, v, 1'b1, 1'b1), "idle level");
               ln[b] <= 1'b0;
               rdst(g, expv(s, v, 1'b1, 1'b0), "falling pin");
               ln[b] <= 1'b1;
               repeat (2) @(posedge clk_sys);
            end
         end
      end
      // a write of an unchanged value must leave the latch alone
      en <= 16'h0001;
      ahb(1'b1, 32'h0, 32'h4);
      ln[0] <= 1'b0;
      rdst(0, 1'b1, "fall latched");
      ahb(1'b1, 32'h0, 32'h4);
      rdst(0, 1'b1, "same value keeps");
      ahb(1'b1, 32'h0, 32'hC);
      rdst(0, 1'b0, "changed value clears");
      ln[0] <= 1'b1;
      ahb(1'b1, 32'h0, 32'h4);
      ln[0] <= 1'b0;
      rdst(0, 1'b1, "fall before entry");
      ack_en <= 1'b1;
      rdst(0, 1'b0, "entry clears latch");
      ack_en <= 1'b0;
      // entry dropped the priority to level 1, sense writes need level 3 again
      ev <= 6'h04;
      @(posedge clk_sys);
      ev <= 6'h0;
      ahb(1'b1, 32'h0, 32'h0);
      ack_en <= 1'b1;
      rdst(0, 1'b1, "low level persists");
      ack_en <= 1'b0;
      ev <= 6'h04;
      @(posedge clk_sys);
      ev <= 6'h0;
      ln[0] <= 1'b1;
      en <= 16'h0021;
      ahb(1'b1, 32'h0, 32'h4);
      ln[5] <= 1'b0;
      rdst(0, 1'b1, "pins ored");
      ahb(1'b0, 32'h8, 32'h0);
      chkv(rd, 32'h8002FFF6, "vector register");
      ln[5] <= 1'b1;
      gnd <= 6'h01;
      ahb(1'b1, 32'h0, 32'hC);
      ln[5] <= 1'b0;
      rdst(0, 1'b0, "grounded pin masks");
      for (k = 0; k < 5; k++) begin
         ev <= pe[k];
         @(posedge clk_sys);
         ev <= 6'h0;
         @(posedge clk_sys);
         #1;
         chkv({30'h0, prio}, {30'h0, pp[k]}, "priority");
         @(posedge clk_sys);
      end
      ahb(1'b1, 32'h0, 32'h55);
      ahb(1'b0, 32'h0, 32'h0);
      chkv(rd, 32'hC, "write below level 3");
      ev <= 6'h04;
      @(posedge clk_sys);
      ev <= 6'h0;
      repeat (2) @(posedge clk_sys);
      ahb(1'b1, 32'h0, 32'h55);
      ahb(1'b0, 32'h0, 32'h0);
      chkv(rd, 32'h55, "write at level 3");
      ahb(1'b0, 32'h40, 32'h0);
      chkv(rd, 32'h0, "unmapped read");
      reset <= 1'b1;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      ahb(1'b0, 32'h0, 32'h0);
      chkv(rd, 32'h0, "sense after second reset");
      stop_test();
   end
endmodule
